// *** core/dram_maint_pkg.sv ***
package dram_maint_pkg;

  // ==========================================================
  // Array geometry
  localparam int BANK_BITS = 5;
  localparam int ROW_BITS = 9;
  localparam logic [4:0] BANK_MAX = 5'h1F;
  localparam int DEV_BITS = 6;

  // ==========================================================
  // Self-refresh time base
  localparam longint REF_INTERVAL_NS = 32000000;
  localparam int CLK_PERIOD_NS = 40;
  localparam longint SUBINT_NS = REF_INTERVAL_NS >> (BANK_BITS + ROW_BITS);
  // Longest time: rounded down, never below one cycle
  localparam int SUBINT_CYCLES = (SUBINT_NS / CLK_PERIOD_NS) < 1 ? 1
                                 : int'(SUBINT_NS / CLK_PERIOD_NS);

  // ==========================================================
  // Channel timing, in channel clock cycles
  localparam int CAC_LINK = 8;
  localparam int CAL_PKT_LINK = 4;
  localparam logic [1:0] TEMP_CALIBRATE_CMD_QUIET_DELAY = 2'h2;
  localparam logic [7:0] TCQUIET_LINK = 8'h8C;

  // ==========================================================
  // Calibration packet drive
  localparam logic [1:0] CAL_PATTERN = 2'h2;
  localparam int CAL_LSB = 3;
  localparam int TSQ_POS = 5;
  localparam logic [8:0] CAL_OE_A = 9'h038;
  localparam logic [8:0] CAL_OE_B = 9'h018;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_REFRESH = 12'h008;
  localparam logic [11:0] ADDR_CAL = 12'h00C;
  localparam int CTRL_NSR_POS = 0;
  localparam int CTRL_DEV_LSB = 8;
  localparam int CTRL_TSQ_POS = 16;
  localparam int STATUS_SELF_POS = 2;
  localparam int STATUS_QUIET_POS = 3;
  localparam int STATUS_CALBUSY_POS = 4;
  localparam int REFRESH_BANK_LSB = 16;
  localparam int CAL_SLEW_LSB = 8;
  localparam logic [5:0] DEV_ID_RESET = 6'h00;
  localparam logic [5:0] IOL_RESET = 6'h20;
  localparam logic [3:0] SLEW_RESET = 4'h8;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    cmd_none,
    refresh_activate_cmd,
    refresh_precharge_cmd,
    cmd_attention,
    cmd_relax,
    cmd_nap,
    cmd_powerdown,
    cmd_wake,
    temp_cal_enable_cmd,
    temp_calibrate_cmd,
    cmd_calibrate,
    sample_cmd
  } cmd_type;

  typedef enum logic [1:0] {
    standby_state,
    attention_state,
    nap_state,
    powerdown_state
  } power_type;

endpackage

// *** core/refresh_timebase.sv ***
`timescale 1ns/10ps
module refresh_timebase
  import dram_maint_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic run, // Count while self-refresh runs
  output logic tick // One-cycle pulse per refresh sub-interval
);

  localparam int CW = $clog2(SUBINT_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(SUBINT_CYCLES - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_tick;

  // ==========================================================
  // Interval counter
  always_comb
  begin
    next_count = '0;
    next_tick = 1'b0;
    if (run)
    begin
      if (count == LAST)
        next_tick = 1'b1;
      else
        next_count = count + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule

// *** core/dram_refresh_and_calibration.sv ***
`timescale 1ns/10ps
module dram_refresh_and_calibration
  import dram_maint_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic chan_clk, // Channel clock, sampled
  input wire cmd_type cmd_code, // Decoded channel command
  input wire logic broadcast_bit_true, // Broadcast bit, true half
  input wire logic broadcast_bit_false, // Broadcast bit, false half
  input wire logic [5:0] device_addr_field, // Addressed device
  input wire logic [4:0] bank_addr, // Bank field of the command
  input wire logic iol_compare, // Output level above reference
  output logic [8:0] data_wires_a_out, // A data wires, drive value
  output logic [8:0] data_wires_a_oe, // A data wires, drive enable
  output logic [8:0] data_wires_b_out, // B data wires, drive value
  output logic [8:0] data_wires_b_oe, // B data wires, drive enable
  output logic core_act, // Core activate pulse
  output logic core_pre, // Core precharge pulse
  output logic [4:0] core_bank, // Bank of the core operation
  output logic [8:0] core_row, // Row of the core activate
  output logic self_refresh, // Self-refresh running
  output logic temp_quiet, // Temperature quiet window open
  output logic [5:0] iol_code, // Output current setting
  output logic [3:0] slew_code // Output slew setting
);

  localparam int SW = 19;

  // ==========================================================
  // Channel input synchroniser
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic chan_prev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      chan_prev <= 1'b0;
    end
    else
    begin
      sync1 <= {chan_clk, broadcast_bit_true, broadcast_bit_false, device_addr_field,
                bank_addr, cmd_code, iol_compare};
      sync2 <= sync1;
      chan_prev <= sync2[18];
    end
  end

  logic link_edge;
  logic bcast;
  logic [5:0] s_dev;
  logic [4:0] s_bank;
  cmd_type s_cmd;
  logic s_cmp;
  assign link_edge = sync2[18] & ~chan_prev;
  assign bcast = sync2[17] & sync2[16];
  assign s_dev = sync2[15:10];
  assign s_bank = sync2[9:5];
  assign s_cmd = cmd_type'(sync2[4:1]);
  assign s_cmp = sync2[0];

  // ==========================================================
  // APB slave, no wait states
  logic sleep_selfrefresh_enable;
  logic temp_sensor_status_bit;
  logic [5:0] dev_id;
  logic next_nsr;
  logic next_tsq;
  logic [5:0] next_dev_id;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  power_type pstate;
  logic [8:0] row_cnt;
  logic [4:0] bank_cnt;
  logic cal_busy;

  always_comb
  begin
    next_nsr = sleep_selfrefresh_enable;
    next_tsq = temp_sensor_status_bit;
    next_dev_id = dev_id;
    next_prdata = prdata;
    next_pready = psel & ~penable;
    next_pslverr = 1'b0;
    if (psel && !penable)
    begin
      next_prdata = '0;
      case (paddr)
        ADDR_CTRL:
        begin
          next_prdata[CTRL_NSR_POS] = sleep_selfrefresh_enable;
          next_prdata[CTRL_DEV_LSB +: DEV_BITS] = dev_id;
          next_prdata[CTRL_TSQ_POS] = temp_sensor_status_bit;
        end
        ADDR_STATUS:
        begin
          next_prdata[1:0] = pstate;
          next_prdata[STATUS_SELF_POS] = self_refresh;
          next_prdata[STATUS_QUIET_POS] = temp_quiet;
          next_prdata[STATUS_CALBUSY_POS] = cal_busy;
        end
        ADDR_REFRESH:
        begin
          next_prdata[ROW_BITS-1:0] = row_cnt;
          next_prdata[REFRESH_BANK_LSB +: BANK_BITS] = bank_cnt;
        end
        ADDR_CAL:
        begin
          next_prdata[5:0] = iol_code;
          next_prdata[CAL_SLEW_LSB +: 4] = slew_code;
        end
        default:
          next_pslverr = 1'b1;
      endcase
    end
    if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
    begin
      next_nsr = pwdata[CTRL_NSR_POS];
      next_dev_id = pwdata[CTRL_DEV_LSB +: DEV_BITS];
      next_tsq = pwdata[CTRL_TSQ_POS];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sleep_selfrefresh_enable <= 1'b0;
      temp_sensor_status_bit <= 1'b0;
      dev_id <= DEV_ID_RESET;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      sleep_selfrefresh_enable <= next_nsr;
      temp_sensor_status_bit <= next_tsq;
      dev_id <= next_dev_id;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // Self-refresh time base
  logic sr_tick;

  refresh_timebase u_timebase (
    .pclk(pclk),
    .presetn(presetn),
    .run(self_refresh),
    .tick(sr_tick)
  );

  // ==========================================================
  // Maintenance state
  power_type saved_state;
  power_type next_pstate;
  power_type next_saved_state;
  logic [8:0] next_row_cnt;
  logic [4:0] next_bank_cnt;
  logic sr_pre_pending;
  logic next_sr_pre_pending;
  logic next_core_act;
  logic next_core_pre;
  logic [4:0] next_core_bank;
  logic [8:0] next_core_row;
  logic next_self_refresh;
  logic [1:0] temp_calibrate_cmd_delay;
  logic [1:0] next_temp_calibrate_cmd_delay;
  logic [7:0] quiet_cnt;
  logic [7:0] next_quiet_cnt;
  logic next_temp_quiet;
  logic [CAC_LINK-1:0] cal_pipe;
  logic [CAC_LINK-1:0] sam_pipe;
  logic [CAC_LINK-1:0] next_cal_pipe;
  logic [CAC_LINK-1:0] next_sam_pipe;
  logic [2:0] pkt_cnt;
  logic [2:0] next_pkt_cnt;
  logic pkt_sample;
  logic next_pkt_sample;
  logic [5:0] next_iol_code;
  logic [3:0] next_slew_code;
  logic [8:0] next_a_out;
  logic [8:0] next_a_oe;
  logic [8:0] next_b_oe;
  logic mine;

  assign mine = bcast | (s_dev == dev_id);
  assign cal_busy = pkt_cnt != 3'h0;

  always_comb
  begin
    next_pstate = pstate;
    next_saved_state = saved_state;
    next_row_cnt = row_cnt;
    next_bank_cnt = bank_cnt;
    next_sr_pre_pending = 1'b0;
    next_core_act = 1'b0;
    next_core_pre = 1'b0;
    next_core_bank = core_bank;
    next_core_row = core_row;
    next_temp_calibrate_cmd_delay = temp_calibrate_cmd_delay;
    next_quiet_cnt = quiet_cnt;
    next_temp_quiet = temp_quiet;
    next_cal_pipe = cal_pipe;
    next_sam_pipe = sam_pipe;
    next_pkt_cnt = pkt_cnt;
    next_pkt_sample = pkt_sample;
    next_iol_code = iol_code;
    next_slew_code = slew_code;
    if (link_edge)
    begin
      case (s_cmd)
        refresh_activate_cmd:
          // Power state is left alone here, broadcast or not
          if (mine && !self_refresh)
          begin
            next_core_act = 1'b1;
            next_core_bank = s_bank;
            next_core_row = row_cnt;
            if (s_bank == BANK_MAX)
              next_row_cnt = row_cnt + 9'h001;
          end
        refresh_precharge_cmd:
          if (mine && !self_refresh)
          begin
            next_core_pre = 1'b1;
            next_core_bank = s_bank;
          end
        cmd_attention:
          if (!bcast && mine && pstate == standby_state)
            next_pstate = attention_state;
        cmd_relax:
          if (mine && pstate == attention_state)
            next_pstate = standby_state;
        cmd_nap, cmd_powerdown:
          if (mine && (pstate == standby_state || pstate == attention_state))
          begin
            next_saved_state = pstate;
            next_pstate = (s_cmd == cmd_nap) ? nap_state : powerdown_state;
            next_bank_cnt = '0;
          end
        cmd_wake:
          if (mine && (pstate == nap_state || pstate == powerdown_state))
            next_pstate = saved_state;
        temp_calibrate_cmd:
          if (bcast)
            next_temp_calibrate_cmd_delay = TEMP_CALIBRATE_CMD_QUIET_DELAY;
        default:
          next_pstate = pstate;
      endcase
      if (temp_quiet)
      begin
        next_quiet_cnt = quiet_cnt - 8'h01;
        if (quiet_cnt == 8'h01)
        begin
          next_temp_quiet = 1'b0;
          if (s_cmp && slew_code != 4'hF)
            next_slew_code = slew_code + 4'h1;
          else if (!s_cmp && slew_code != 4'h0)
            next_slew_code = slew_code - 4'h1;
        end
      end
      // Window opens on the second channel edge after the command;
      // a window opening as the old one closes wins over the close
      if (temp_calibrate_cmd_delay != 2'h0)
      begin
        next_temp_calibrate_cmd_delay = temp_calibrate_cmd_delay - 2'h1;
        if (temp_calibrate_cmd_delay == 2'h1)
        begin
          next_temp_quiet = 1'b1;
          next_quiet_cnt = TCQUIET_LINK;
        end
      end
      // Calibration is answered only when addressed to this device alone
      next_cal_pipe = {cal_pipe[CAC_LINK-2:0],
                       !bcast && mine && (s_cmd == cmd_calibrate || s_cmd == sample_cmd)};
      next_sam_pipe = {sam_pipe[CAC_LINK-2:0], !bcast && mine && s_cmd == sample_cmd};
      if (pkt_cnt != 3'h0)
      begin
        next_pkt_cnt = pkt_cnt - 3'h1;
        if (pkt_cnt == 3'h1 && pkt_sample)
        begin
          if (s_cmp && iol_code != 6'h00)
            next_iol_code = iol_code - 6'h01;
          else if (!s_cmp && iol_code != 6'h3F)
            next_iol_code = iol_code + 6'h01;
        end
      end
      if (cal_pipe[CAC_LINK-1])
      begin
        next_pkt_cnt = 3'(CAL_PKT_LINK);
        next_pkt_sample = sam_pipe[CAC_LINK-1];
      end
    end
    next_self_refresh = (next_pstate == powerdown_state) ||
                        (next_pstate == nap_state && sleep_selfrefresh_enable);
    if (self_refresh && sr_tick)
    begin
      next_core_act = 1'b1;
      next_core_bank = bank_cnt;
      next_core_row = row_cnt;
      next_sr_pre_pending = 1'b1;
    end
    if (sr_pre_pending)
    begin
      next_core_pre = 1'b1;
      next_bank_cnt = bank_cnt + 5'h01;
      if (bank_cnt == BANK_MAX)
        next_row_cnt = row_cnt + 9'h001;
    end
    next_a_out = '0;
    next_a_oe = '0;
    next_b_oe = '0;
    if (next_pkt_cnt != 3'h0)
    begin
      next_a_out[CAL_LSB +: 2] = CAL_PATTERN;
      next_a_out[TSQ_POS] = temp_sensor_status_bit;
      next_a_oe = CAL_OE_A;
      next_b_oe = CAL_OE_B;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pstate <= powerdown_state;
      saved_state <= standby_state;
      row_cnt <= '0;
      bank_cnt <= '0;
      sr_pre_pending <= 1'b0;
      core_act <= 1'b0;
      core_pre <= 1'b0;
      core_bank <= '0;
      core_row <= '0;
      self_refresh <= 1'b0;
      temp_calibrate_cmd_delay <= '0;
      quiet_cnt <= '0;
      temp_quiet <= 1'b0;
      cal_pipe <= '0;
      sam_pipe <= '0;
      pkt_cnt <= '0;
      pkt_sample <= 1'b0;
      iol_code <= IOL_RESET;
      slew_code <= SLEW_RESET;
      data_wires_a_out <= '0;
      data_wires_a_oe <= '0;
      data_wires_b_out <= '0;
      data_wires_b_oe <= '0;
    end
    else
    begin
      pstate <= next_pstate;
      saved_state <= next_saved_state;
      row_cnt <= next_row_cnt;
      bank_cnt <= next_bank_cnt;
      sr_pre_pending <= next_sr_pre_pending;
      core_act <= next_core_act;
      core_pre <= next_core_pre;
      core_bank <= next_core_bank;
      core_row <= next_core_row;
      self_refresh <= next_self_refresh;
      temp_calibrate_cmd_delay <= next_temp_calibrate_cmd_delay;
      quiet_cnt <= next_quiet_cnt;
      temp_quiet <= next_temp_quiet;
      cal_pipe <= next_cal_pipe;
      sam_pipe <= next_sam_pipe;
      pkt_cnt <= next_pkt_cnt;
      pkt_sample <= next_pkt_sample;
      iol_code <= next_iol_code;
      slew_code <= next_slew_code;
      data_wires_a_out <= next_a_out;
      data_wires_a_oe <= next_a_oe;
      data_wires_b_out <= '0;
      data_wires_b_oe <= next_b_oe;
    end
  end

endmodule

// *** verification/dram_maint_asserts.sv ***
`timescale 1ns/10ps
module dram_maint_asserts
  import dram_maint_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic [11:0] paddr, // Address
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [8:0] data_wires_a_out, // A value
  input wire logic [8:0] data_wires_a_oe, // A enable
  input wire logic [8:0] data_wires_b_oe, // B enable
  input wire logic core_act, // Activate
  input wire logic core_pre, // Precharge
  input wire logic [4:0] core_bank, // Bank
  input wire logic [8:0] core_row, // Row
  input wire logic self_refresh, // Self-refresh
  input wire logic temp_quiet, // Quiet window
  input wire logic [5:0] iol_code, // Current code
  input wire logic [3:0] slew_code // Slew code
);
  // ==========
  // Last activate; the row counter is shared by both refresh modes
  logic seen;
  logic top;
  logic gap_ok;
  logic [7:0] gap;
  logic [8:0] last_row;
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {seen, top, gap_ok, gap, last_row} <= '0;
    else
    begin
      seen <= seen | core_act;
      top <= core_act ? (core_bank == BANK_MAX) : top;
      last_row <= core_act ? core_row : last_row;
      gap <= core_act ? 8'h01 : gap + {7'h00, gap != 8'hFF};
      gap_ok <= self_refresh & (gap_ok | core_act);
    end
  // ==========
  // Properties
  sequence s_self_act;
    self_refresh && core_act;
  endsequence
  a_self_pair: assert property (s_self_act |=> core_pre && core_bank == $past(core_bank))
    else $error("self-refresh activate without precharge");
  a_self_gap: assert property (gap_ok && self_refresh && core_act |-> gap == 8'(SUBINT_CYCLES))
    else $error("self-refresh spacing wrong");
  a_row_advance: assert property (core_act && seen |-> core_row == last_row + {8'h00, top})
    else $error("refresh row not advanced correctly");
  a_cal_drive: assert property (|data_wires_a_oe |-> data_wires_a_oe == CAL_OE_A
    && data_wires_b_oe == CAL_OE_B && data_wires_a_out[4:3] == CAL_PATTERN)
    else $error("calibration drive pattern wrong");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_unmapped_err: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > ADDR_CAL))
    else $error("error response wrong");
  a_iol_step: assert property (!$stable(iol_code) |-> (|data_wires_a_oe || $past(|data_wires_a_oe))
    && (6'(iol_code - $past(iol_code)) inside {6'h01, 6'h3F}))
    else $error("current code step wrong");
  a_slew_step: assert property (!$stable(slew_code) |-> ($past(temp_quiet) || $past(temp_quiet, 2))
    && (4'(slew_code - $past(slew_code)) inside {4'h1, 4'hF}))
    else $error("slew code step wrong");
endmodule

bind dram_refresh_and_calibration dram_maint_asserts u_chk (
  .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .data_wires_a_out, .data_wires_a_oe, .data_wires_b_oe, .core_act, .core_pre,
  .core_bank, .core_row, .self_refresh, .temp_quiet, .iol_code, .slew_code
);

// *** verification/channel_model.sv ***
`timescale 1ns/10ps
module channel_model
  import dram_maint_pkg::*;
#(
  parameter int T_RAS = 3
)
(
  input wire logic pclk, // Clock
  input wire logic chan_clk, // Channel clock
  output cmd_type cmd_code, // Command
  output logic broadcast_bit_true, // Broadcast, true
  output logic broadcast_bit_false, // Broadcast, false
  output logic [5:0] device_addr_field, // Device
  output logic [4:0] bank_addr // Bank
);
  cmd_type p_cmd;
  logic p_bc;
  logic [5:0] p_dev;
  logic [4:0] p_bank;
  logic pend = 1'b0;
  initial
  begin
    cmd_code = cmd_none;
    broadcast_bit_true = 1'b0;
    broadcast_bit_false = 1'b0;
    device_addr_field = 6'h00;
    bank_addr = 5'h00;
  end
  // ==========
  // One command per channel cycle, held across the rising edge
  always @(negedge chan_clk)
  begin
    @(posedge pclk);
    if (pend)
    begin
      cmd_code <= p_cmd;
      broadcast_bit_true <= p_bc;
      broadcast_bit_false <= p_bc;
      device_addr_field <= p_dev;
      bank_addr <= p_bank;
      pend = 1'b0;
    end
    else
    begin
      // Idle fields toggle so a stale value is never mistaken for a command
      cmd_code <= cmd_none;
      broadcast_bit_true <= 1'b0;
      broadcast_bit_false <= 1'b0;
      device_addr_field <= ~device_addr_field;
      bank_addr <= ~bank_addr;
    end
  end
  task automatic send(input cmd_type c, input logic bc, input logic [5:0] d, input logic [4:0] b);
    p_cmd = c;
    p_bc = bc;
    p_dev = d;
    p_bank = b;
    pend = 1'b1;
    for (int n = 0; pend && n < 40; n++)
      @(negedge pclk);
  endtask
  task automatic refresh(input logic [4:0] b);
    send(refresh_activate_cmd, 1'b1, 6'h00, b);
    repeat (T_RAS) @(negedge chan_clk);
    send(refresh_precharge_cmd, 1'b1, 6'h00, b);
    repeat (T_RAS) @(negedge chan_clk);
  endtask
  task automatic cal(input logic [5:0] d, input logic bc);
    for (int j = 0; j < 4; j++)
    begin
      send(j == 3 ? sample_cmd : cmd_calibrate, bc, d, 5'h00);
      repeat (CAL_PKT_LINK) @(negedge chan_clk);
    end
  endtask
  task automatic temp_cal();
    send(temp_cal_enable_cmd, 1'b1, 6'h00, 5'h00);
    repeat (150) @(negedge chan_clk);
    send(temp_calibrate_cmd, 1'b1, 6'h00, 5'h00);
  endtask
endmodule

// *** verification/test_dram_refresh_and_calibration.sv ***
`timescale 1ns/10ps
module test_dram_refresh_and_calibration
  import dram_maint_pkg::*;
;
  logic pclk, presetn, chan_clk, psel, penable, pwrite, iol_compare, pready, pslverr;
  logic broadcast_bit_true, broadcast_bit_false, core_act, core_pre, self_refresh, temp_quiet;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  cmd_type cmd_code;
  logic [5:0] device_addr_field, iol_code;
  logic [4:0] bank_addr, core_bank;
  logic [8:0] data_wires_a_out, data_wires_a_oe, data_wires_b_out, data_wires_b_oe, core_row;
  logic [3:0] slew_code;
  logic rerr;
  int n_errors = 0;
  int checked = 0;
  int drv = 0;
  int qn = 0;
  dram_refresh_and_calibration u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .chan_clk, .cmd_code, .broadcast_bit_true,
    .broadcast_bit_false, .device_addr_field, .bank_addr, .iol_compare, .data_wires_a_out,
    .data_wires_a_oe, .data_wires_b_out, .data_wires_b_oe, .core_act, .core_pre, .core_bank,
    .core_row, .self_refresh, .temp_quiet, .iol_code, .slew_code);
  channel_model u_ctrl (.pclk, .chan_clk, .cmd_code, .broadcast_bit_true,
    .broadcast_bit_false, .device_addr_field, .bank_addr);
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Channel clock runs free, out of phase with the bus clock
  initial
  begin
    chan_clk = 1'b0;
    #7;
    forever #160 chan_clk = ~chan_clk;
  end
  // Watchdog: a hung handshake ends the run as a failure
  initial
  begin
    repeat (90000) @(posedge pclk);
    n_errors++;
    report_and_stop();
  end
  always @(negedge pclk)
  begin
    if (temp_quiet === 1'b1)
      qn++;
    if (data_wires_a_oe !== 9'h000)
    begin
      drv++;
      check(data_wires_a_out, {3'h0, 1'b1, CAL_PATTERN, 3'h0});
      check({data_wires_b_out, data_wires_b_oe}, {9'h000, CAL_OE_B});
    end
  end
  // ==========
  // Tasks
  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      n_errors++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rdat, rerr);
    check(rdat, e);
  endtask
  task automatic wait_pulse(input logic pre);
    int n;
    n = 0;
    while ((pre ? core_pre : core_act) !== 1'b1 && n < 200)
    begin
      @(negedge pclk);
      n++;
    end
    if (n >= 200)
    begin
      n_errors++;
      report_and_stop();
    end
  endtask
  task automatic cmd_and_wait(input cmd_type c, input logic bc);
    u_ctrl.send(c, bc, 6'h00, 5'h00);
    repeat (40) @(negedge pclk);
  endtask
  task automatic refresh_check(input logic [4:0] b, input logic [8:0] r);
    fork
      u_ctrl.refresh(b);
      begin
        wait_pulse(1'b0);
        check({core_bank, core_row}, {b, r});
        wait_pulse(1'b1);
        check(core_bank, b);
      end
    join
  endtask
  // ==========
  // Sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    iol_compare = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_STATUS, 32'h7);
    rd(ADDR_CAL, {20'h0, SLEW_RESET, 2'h0, IOL_RESET});
    apb(1'b0, 12'h010, 32'h0, rdat, rerr);
    check(rerr, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF, rdat, rerr);
    rd(ADDR_STATUS, 32'h7);
    for (int k = 0; k < 2; k++)
    begin
      wait_pulse(1'b0);
      check({core_bank, core_row}, {k[4:0], 9'h000});
      wait_pulse(1'b1);
      check(core_bank, k[4:0]);
    end
    cmd_and_wait(cmd_wake, 1'b0);
    rd(ADDR_STATUS, 32'h0);
    cmd_and_wait(cmd_attention, 1'b1);
    rd(ADDR_STATUS, 32'h0);
    cmd_and_wait(cmd_attention, 1'b0);
    refresh_check(5'h05, 9'h000);
    for (int i = 0; i < 513; i++)
      refresh_check(5'h1F, i[8:0]);
    rd(ADDR_STATUS, 32'h1);
    cmd_and_wait(cmd_relax, 1'b0);
    for (int k = 1; k >= 0; k--)
    begin
      apb(1'b1, ADDR_CTRL, 32'h10000 | k, rdat, rerr);
      cmd_and_wait(cmd_nap, 1'b0);
      check(self_refresh, k[0]);
      if (k == 1)
      begin
        wait_pulse(1'b0);
        check({core_bank, core_row}, {5'h00, 9'h001});
        rd(ADDR_REFRESH, 32'h00010001);
      end
      cmd_and_wait(cmd_wake, 1'b0);
    end
    cmd_and_wait(cmd_powerdown, 1'b0);
    rd(ADDR_STATUS, 32'h7);
    cmd_and_wait(cmd_wake, 1'b0);
    rd(ADDR_CTRL, 32'h10000);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge pclk);
      iol_compare <= (k == 3);
      drv = 0;
      u_ctrl.cal(6'(k == 1), k == 2);
      repeat (16) @(posedge chan_clk);
      check(drv, (k == 1 || k == 2) ? 0 : CAL_PKT_LINK * 32);
      check(iol_code, (k == 3) ? IOL_RESET : IOL_RESET + 6'h01);
    end
    qn = 0;
    u_ctrl.temp_cal();
    repeat (4) @(posedge chan_clk);
    rd(ADDR_STATUS, 32'h8);
    repeat (156) @(posedge chan_clk);
    check(qn, TCQUIET_LINK * 8);
    check(slew_code, SLEW_RESET + 4'h1);
    report_and_stop();
  end
endmodule
